// >>> rtl/nibble_alu_defs.svh
/*
 * Register offsets, field positions and reset values of the nibble ALU.
 * Assumes a byte-addressed Avalon-MM slave port with 32-bit data.
 */
`ifndef NIBBLE_ALU_DEFS_SVH
`define NIBBLE_ALU_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CMD 5'h00
`define OFS_STATUS 5'h04
`define OFS_PTR 5'h08
`define OFS_UPPER 5'h0c
`define OFS_PAGE 5'h10
`define OFS_CTRL 5'h14

// ****************************************
// Control register fields
// ****************************************
`define CTRL_WAKE_BIT 0
`define CTRL_FAULT_CLR_BIT 1

// ****************************************
// Table word fields
// ****************************************
`define TBL_HI_MSB 7
`define TBL_HI_LSB 4
`define TBL_LO_MSB 3
`define TBL_LO_LSB 0

// ****************************************
// Reset values and bank select codes
// ****************************************
`define RST_NIBBLE 4'h0
`define RST_PTR 9'h000
`define RST_UPPER 3'h0
`define RST_PAGE 6'h00
`define BANK_LOWER 1'b0
`define BANK_UPPER 1'b1

`endif

// >>> rtl/nibble_alu_pkg.sv
/*
 * Types shared by the nibble ALU: opcodes, bus states, command and status words.
 * Assumes the opcode codes below are the ones software writes to the command register.
 */
package nibble_alu_pkg;

    // ****************************************
    // Instruction codes
    // ****************************************
    typedef enum logic [4:0] {
        OP_NOP        = 5'h00,
        OP_LOAD_IMM   = 5'h01,
        OP_TABLE      = 5'h02,
        OP_SEL_UPPER  = 5'h03,
        OP_SEL_LOWER  = 5'h04,
        OP_ADD_MEM    = 5'h05,
        OP_ADD_MEM_C  = 5'h06,
        OP_ADD_IMM    = 5'h07,
        OP_AND        = 5'h08,
        OP_OR         = 5'h09,
        OP_SET_C      = 5'h0a,
        OP_CLR_C      = 5'h0b,
        OP_SKIP_CC    = 5'h0c,
        OP_COMPL      = 5'h0d,
        OP_ROTATE     = 5'h0e,
        OP_SET_BIT    = 5'h0f,
        OP_CLR_BIT    = 5'h10,
        OP_SKIP_BIT0  = 5'h11,
        OP_SKIP_EQ_M  = 5'h12,
        OP_SKIP_EQ_I  = 5'h13
    } op_t;

    // ****************************************
    // Bus and execution states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROM  = 2'b01,
        ST_EXEC = 2'b10,
        ST_ACK  = 2'b11
    } state_t;

    typedef struct packed {
        logic [3:0] imm;
        op_t op;
    } cmd_t;

    typedef struct packed {
        logic fault;
        logic la_run;
        logic bank;
        logic skip;
        logic carry;
        logic [3:0] breg;
        logic [3:0] acc;
    } status_t;

endpackage

// >>> rtl/nibble_alu_skip_logic.sv
/*
 * Nibble ALU datapath with skip logic, driven by instructions written over Avalon-MM.
 * Assumes data RAM and table ROM with one-cycle registered reads on ref_clk,
 * and a sequencer that reports a free return-stack level on the same clock.
 */
// Notes on behaviour
// [RL1] Load immediate; run of loads keeps first only
// [RL2] Table read: high nibble second, low accumulator
// [RL3] Table read holds one stack level
// [RL4] Upper bank select reaches pages 64-127
// [RL5] Lower bank select reaches pages 0-63
// [RL6] Reset and wake select lower bank
// [RL7] Add memory, carry untouched
// [RL8] Add memory with carry, carry updated
// [RL9] Add immediate, skip when no overflow
// [RL10] AND accumulator with memory
// [RL11] OR accumulator with memory
// [RL12] Set carry only
// [RL13] Clear carry only
// [RL14] Skip when carry clear, carry kept
// [RL15] Complement accumulator
// [RL16] Rotate carry and accumulator right
// [RL17] Set memory bit j
// [RL18] Clear memory bit j
// [RL19] Skip when memory bit j zero
// [RL20] Skip when accumulator equals memory
// [RL21] Skip when accumulator equals immediate
// [RL22] Skipped instruction changes nothing
`include "nibble_alu_defs.svh"

module nibble_alu_skip_logic
    import nibble_alu_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Data RAM
    output logic [8:0] ram_addr,
    input wire logic [3:0] ram_rdata,
    output logic [3:0] ram_wdata,
    output logic ram_we,
    // Table ROM
    output logic [13:0] rom_addr,
    input wire logic [9:0] rom_rdata,
    // Return stack
    input wire logic stack_level_free,
    output logic stack_claim
);

    // ****************************************
    // Declarations
    // ****************************************
    state_t state_ff;
    state_t nxt_state;
    cmd_t cmd_ff;
    status_t status_w;
    logic [31:0] rdata_ff;
    logic wait_ff;
    logic [3:0] acc_ff;
    logic [3:0] nxt_acc;
    logic [3:0] breg_ff;
    logic [3:0] nxt_breg;
    logic carry_ff;
    logic nxt_carry;
    logic skip_ff;
    logic nxt_skip;
    logic la_run_ff;
    logic nxt_la_run;
    logic bank_ff;
    logic nxt_bank;
    logic fault_ff;
    logic fault_set;
    logic refused_ff;
    logic [8:0] ptr_ff;
    logic [2:0] upper_ff;
    logic [5:0] page_ff;
    logic ram_we_ff;
    logic nxt_we;
    logic [3:0] ram_wdata_ff;
    logic [3:0] nxt_wdata;
    logic [13:0] rom_addr_ff;
    logic claim_ff;
    logic [4:0] sum_w;
    logic [3:0] add_b;
    logic [3:0] mask_w;
    logic skipped;
    logic live;
    logic idle_wr;
    logic idle_rd;
    logic new_tbl;
    logic wake_wr;
    logic fault_clr;
    op_t op;
    op_t new_op;

    function automatic logic [3:0] bit_mask(input logic [1:0] j);
        bit_mask = 4'h1 << j;
    endfunction

    function automatic logic two_lanes(input logic [3:0] be);
        two_lanes = be[0] & be[1];
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    assign op = cmd_ff.op;
    assign new_op = op_t'(avs_writedata[4:0]);
    assign idle_wr = (state_ff == ST_IDLE) && avs_write;
    assign idle_rd = (state_ff == ST_IDLE) && avs_read;
    assign new_tbl = idle_wr && (avs_address == `OFS_CMD) && two_lanes(avs_byteenable)
                     && (new_op == OP_TABLE) && !skip_ff;
    assign wake_wr = idle_wr && (avs_address == `OFS_CTRL) && avs_byteenable[0]
                     && avs_writedata[`CTRL_WAKE_BIT];
    assign fault_clr = idle_wr && (avs_address == `OFS_CTRL) && avs_byteenable[0]
                       && avs_writedata[`CTRL_FAULT_CLR_BIT];
    // [RL1] Load run suppression
    assign skipped = skip_ff | ((op == OP_LOAD_IMM) & la_run_ff);
    assign live = (state_ff == ST_EXEC) && !skipped;
    assign mask_w = bit_mask(cmd_ff.imm[1:0]);
    assign add_b = (op == OP_ADD_IMM) ? cmd_ff.imm : ram_rdata;
    assign sum_w = {1'b0, acc_ff} + {1'b0, add_b} + {4'h0, (op == OP_ADD_MEM_C) & carry_ff};

    assign status_w = '{fault: fault_ff, la_run: la_run_ff, bank: bank_ff, skip: skip_ff,
                        carry: carry_ff, breg: breg_ff, acc: acc_ff};

    // ****************************************
    // Bus state machine
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (idle_wr && (avs_address == `OFS_CMD) && two_lanes(avs_byteenable)) begin
                    nxt_state = (new_tbl && stack_level_free) ? ST_ROM : ST_EXEC;
                end else if (avs_read || avs_write) begin
                    nxt_state = ST_ACK;
                end
            end
            ST_ROM: nxt_state = ST_EXEC;
            ST_EXEC: nxt_state = ST_ACK;
            ST_ACK: nxt_state = ST_IDLE;
        endcase
    end

    // Waitrequest idles high so no request is ever taken early
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= (nxt_state != ST_ACK);
            if (idle_rd) begin
                unique case (avs_address)
                    `OFS_CMD: rdata_ff <= {23'h0, cmd_ff};
                    `OFS_STATUS: rdata_ff <= {19'h0, status_w};
                    `OFS_PTR: rdata_ff <= {23'h0, ptr_ff};
                    `OFS_UPPER: rdata_ff <= {29'h0, upper_ff};
                    `OFS_PAGE: rdata_ff <= {26'h0, page_ff};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_ff <= '{imm: `RST_NIBBLE, op: OP_NOP};
            ptr_ff <= `RST_PTR;
            upper_ff <= `RST_UPPER;
            page_ff <= `RST_PAGE;
            refused_ff <= 1'b0;
        end else if (idle_wr) begin
            if (avs_address == `OFS_CMD && two_lanes(avs_byteenable)) begin
                cmd_ff <= cmd_t'(avs_writedata[8:0]);
                // [RL3] No free level refuses
                refused_ff <= new_tbl && !stack_level_free;
            end
            if (avs_address == `OFS_PTR && two_lanes(avs_byteenable)) begin
                ptr_ff <= avs_writedata[8:0];
            end
            if (avs_address == `OFS_UPPER && avs_byteenable[0]) begin
                upper_ff <= avs_writedata[2:0];
            end
            if (avs_address == `OFS_PAGE && avs_byteenable[0]) begin
                page_ff <= avs_writedata[5:0];
            end
        end
    end

    // ****************************************
    // Instruction execution
    // ****************************************
    always_comb begin
        nxt_acc = acc_ff;
        nxt_breg = breg_ff;
        nxt_carry = carry_ff;
        nxt_skip = 1'b0;
        nxt_la_run = 1'b0;
        nxt_bank = bank_ff;
        nxt_we = 1'b0;
        nxt_wdata = ram_rdata;
        fault_set = 1'b0;
        if (skipped) begin
            // [RL22] Skipped is no-op
            nxt_la_run = (op == OP_LOAD_IMM);
        end else begin
            unique case (op)
                // [RL1] Load immediate
                OP_LOAD_IMM: begin
                    nxt_acc = cmd_ff.imm;
                    nxt_la_run = 1'b1;
                end
                // [RL2] Table split
                OP_TABLE: begin
                    if (refused_ff) begin
                        fault_set = 1'b1;
                    end else begin
                        nxt_breg = rom_rdata[`TBL_HI_MSB:`TBL_HI_LSB];
                        nxt_acc = rom_rdata[`TBL_LO_MSB:`TBL_LO_LSB];
                    end
                end
                // [RL4] Upper bank
                OP_SEL_UPPER: nxt_bank = `BANK_UPPER;
                // [RL5] Lower bank
                OP_SEL_LOWER: nxt_bank = `BANK_LOWER;
                // [RL7] Add memory
                OP_ADD_MEM: nxt_acc = sum_w[3:0];
                // [RL8] Add with carry
                OP_ADD_MEM_C: {nxt_carry, nxt_acc} = sum_w;
                // [RL9] Add immediate skip
                OP_ADD_IMM: begin
                    nxt_acc = sum_w[3:0];
                    nxt_skip = !sum_w[4];
                end
                // [RL10] Bitwise AND
                OP_AND: nxt_acc = acc_ff & ram_rdata;
                // [RL11] Bitwise OR
                OP_OR: nxt_acc = acc_ff | ram_rdata;
                // [RL12] Set carry
                OP_SET_C: nxt_carry = 1'b1;
                // [RL13] Clear carry
                OP_CLR_C: nxt_carry = 1'b0;
                // [RL14] Carry clear skip
                OP_SKIP_CC: nxt_skip = !carry_ff;
                // [RL15] Complement accumulator
                OP_COMPL: nxt_acc = ~acc_ff;
                // [RL16] Rotate through carry
                OP_ROTATE: {nxt_carry, nxt_acc} = {acc_ff[0], carry_ff, acc_ff[3:1]};
                // [RL17] Set memory bit
                OP_SET_BIT: begin
                    nxt_we = 1'b1;
                    nxt_wdata = ram_rdata | mask_w;
                end
                // [RL18] Clear memory bit
                OP_CLR_BIT: begin
                    nxt_we = 1'b1;
                    nxt_wdata = ram_rdata & ~mask_w;
                end
                // [RL19] Bit zero skip
                OP_SKIP_BIT0: nxt_skip = ((ram_rdata & mask_w) == 4'h0);
                // [RL20] Memory equal skip
                OP_SKIP_EQ_M: nxt_skip = (acc_ff == ram_rdata);
                // [RL21] Immediate equal skip
                OP_SKIP_EQ_I: nxt_skip = (acc_ff == cmd_ff.imm);
                OP_NOP: nxt_acc = acc_ff;
                default: nxt_acc = acc_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_ff <= `RST_NIBBLE;
            breg_ff <= `RST_NIBBLE;
            carry_ff <= 1'b0;
            skip_ff <= 1'b0;
            la_run_ff <= 1'b0;
        end else if (state_ff == ST_EXEC) begin
            acc_ff <= nxt_acc;
            breg_ff <= nxt_breg;
            carry_ff <= nxt_carry;
            skip_ff <= nxt_skip;
            la_run_ff <= nxt_la_run;
        end
    end

    // [RL6] Lower bank after reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bank_ff <= `BANK_LOWER;
        end else if (wake_wr) begin
            bank_ff <= `BANK_LOWER;
        end else if (state_ff == ST_EXEC) begin
            bank_ff <= nxt_bank;
        end
    end

    // Sticky refusal; a new refusal beats a clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_ff <= 1'b0;
        end else if (state_ff == ST_EXEC && fault_set) begin
            fault_ff <= 1'b1;
        end else if (fault_clr) begin
            fault_ff <= 1'b0;
        end
    end

    // ****************************************
    // Memory and stack ports
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_we_ff <= 1'b0;
            ram_wdata_ff <= `RST_NIBBLE;
            rom_addr_ff <= 14'h0000;
            claim_ff <= 1'b0;
        end else begin
            ram_we_ff <= (state_ff == ST_EXEC) && nxt_we;
            if (state_ff == ST_EXEC) begin
                ram_wdata_ff <= nxt_wdata;
            end
            // [RL4] Bank picks page half
            if (nxt_state == ST_ROM) begin
                rom_addr_ff <= {bank_ff, page_ff, upper_ff, acc_ff};
            end
            // [RL3] Hold stack level
            claim_ff <= (nxt_state == ST_ROM) || (state_ff == ST_ROM);
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign ram_addr = ptr_ff;
    assign ram_wdata = ram_wdata_ff;
    assign ram_we = ram_we_ff;
    assign rom_addr = rom_addr_ff;
    assign stack_claim = claim_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_load_imm: assert property ( // [RL1]
        live && op == OP_LOAD_IMM |=> acc_ff == $past(cmd_ff.imm) && la_run_ff)
        else $error("load immediate wrong");
    a_load_run_drop: assert property ( // [RL1]
        state_ff == ST_EXEC && op == OP_LOAD_IMM && la_run_ff |=> $stable(acc_ff) && la_run_ff)
        else $error("repeated load took effect");
    a_table_split: assert property ( // [RL2]
        live && op == OP_TABLE && !refused_ff |=> {breg_ff, acc_ff} == $past(rom_rdata[7:0]))
        else $error("table nibbles misplaced");
    a_table_stack: assert property ( // [RL3]
        state_ff == ST_ROM |-> stack_claim ##1 stack_claim && state_ff == ST_EXEC)
        else $error("stack level not held");
    a_table_addr: assert property ( // [RL4]
        state_ff == ST_ROM |-> rom_addr == {bank_ff, page_ff, upper_ff, acc_ff})
        else $error("table address wrong");
    a_bank_upper: assert property ( // [RL4]
        live && op == OP_SEL_UPPER |=> bank_ff == `BANK_UPPER)
        else $error("upper bank not selected");
    a_bank_lower: assert property ( // [RL5]
        live && op == OP_SEL_LOWER |=> bank_ff == `BANK_LOWER)
        else $error("lower bank not selected");
    a_bank_wake: assert property ( // [RL6]
        wake_wr |=> bank_ff == `BANK_LOWER)
        else $error("wake left upper bank");
    a_add_mem: assert property ( // [RL7]
        live && op == OP_ADD_MEM |=> acc_ff == $past(acc_ff + ram_rdata) && $stable(carry_ff))
        else $error("add memory wrong");
    a_add_carry: assert property ( // [RL8]
        live && op == OP_ADD_MEM_C |=> {carry_ff, acc_ff}
        == $past({1'b0, acc_ff} + {1'b0, ram_rdata} + {4'h0, carry_ff}))
        else $error("add with carry wrong");
    a_add_imm_skip: assert property ( // [RL9]
        live && op == OP_ADD_IMM |=> $stable(carry_ff) && acc_ff == $past(acc_ff + cmd_ff.imm)
        && skip_ff == ($past({1'b0, acc_ff} + {1'b0, cmd_ff.imm}) < 5'h10))
        else $error("add immediate skip wrong");
    a_logic_ops: assert property ( // [RL10]
        live && op == OP_AND ##1 1'b1 |-> acc_ff == ($past(acc_ff) & $past(ram_rdata)))
        else $error("and result wrong");
    a_or_op: assert property ( // [RL11]
        live && op == OP_OR |=> acc_ff == ($past(acc_ff) | $past(ram_rdata)))
        else $error("or result wrong");
    a_carry_set: assert property ( // [RL12]
        live && op == OP_SET_C |=> carry_ff && $stable(acc_ff) && $stable(breg_ff))
        else $error("set carry wrong");
    a_carry_clear: assert property ( // [RL13]
        live && op == OP_CLR_C |=> !carry_ff && $stable(acc_ff) && $stable(breg_ff))
        else $error("clear carry wrong");
    a_skip_carry: assert property ( // [RL14]
        live && op == OP_SKIP_CC |=> skip_ff == !carry_ff && $stable(carry_ff))
        else $error("carry skip wrong");
    a_compl_acc: assert property ( // [RL15]
        live && op == OP_COMPL |=> acc_ff == ~$past(acc_ff))
        else $error("complement wrong");
    a_rotate_chain: assert property ( // [RL16]
        live && op == OP_ROTATE |=> {acc_ff, carry_ff} == {$past(carry_ff), $past(acc_ff)})
        else $error("rotate wrong");
    a_bit_set: assert property ( // [RL17]
        live && op == OP_SET_BIT |=> ram_we && ram_wdata == ($past(ram_rdata) | $past(mask_w)))
        else $error("bit set wrong");
    a_bit_clear: assert property ( // [RL18]
        live && op == OP_CLR_BIT |=> ram_we && ram_wdata == ($past(ram_rdata) & ~$past(mask_w)))
        else $error("bit clear wrong");
    a_skip_bit: assert property ( // [RL19]
        live && op == OP_SKIP_BIT0 |=> skip_ff == (($past(ram_rdata) & $past(mask_w)) == 4'h0))
        else $error("bit test skip wrong");
    a_skip_eq_mem: assert property ( // [RL20]
        live && op == OP_SKIP_EQ_M |=> skip_ff == ($past(acc_ff) == $past(ram_rdata)))
        else $error("memory compare skip wrong");
    a_skip_eq_imm: assert property ( // [RL21]
        live && op == OP_SKIP_EQ_I |=> skip_ff == ($past(acc_ff) == $past(cmd_ff.imm)))
        else $error("immediate compare skip wrong");
    a_skipped_nop: assert property ( // [RL22]
        state_ff == ST_EXEC && skipped |=> $stable(acc_ff) && $stable(carry_ff) && !ram_we && !skip_ff)
        else $error("skipped instruction acted");

    c_table_read: cover property (live && op == OP_TABLE && !refused_ff);
    c_load_run: cover property (state_ff == ST_EXEC && op == OP_LOAD_IMM && la_run_ff);
    c_add_skip: cover property (live && op == OP_ADD_IMM && !sum_w[4]);
    c_bit_write: cover property (ram_we);

endmodule // nibble_alu_skip_logic

// >>> tb/alu_far_model.sv
/* Far-side model: data RAM, table ROM and return-stack level.
   Assumes one ref_clk and one-cycle registered reads. */
module alu_far_model (
    // Clock
    input wire logic ref_clk,
    // Data RAM
    input wire logic [8:0] ram_addr,
    output logic [3:0] ram_rdata,
    input wire logic [3:0] ram_wdata,
    input wire logic ram_we,
    // Table ROM
    input wire logic [13:0] rom_addr,
    output logic [9:0] rom_rdata,
    // Return stack
    input wire logic free_en,
    output logic stack_level_free,
    input wire logic stack_claim
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mem [512];
    int claim_cyc = 0;
    initial for (int i = 0; i < 512; i++) mem[i] = 4'(i ^ (i >> 4));
    always @(posedge ref_clk) begin
        if (ram_we) mem[ram_addr] <= ram_wdata;
        ram_rdata <= mem[ram_addr];
        // word from whole address; top bits unused so set
        rom_rdata <= {2'h3, rom_addr[7:0] ^ rom_addr[13:6]};
        if (stack_claim) claim_cyc++;
    end
    // free level only when bench allows
    assign stack_level_free = free_en;
endmodule // alu_far_model

// >>> tb/nibble_alu_skip_logic_tb.sv
/* Self-checking bench: Avalon-MM driver, reference model, queue checker.
   Assumes the design package and the far-side model are compiled first. */
module nibble_alu_skip_logic_tb import nibble_alu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest, ram_we, stack_level_free, stack_claim, free_en;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, r;
    logic [8:0] ram_addr, pt;
    logic [3:0] ram_rdata, ram_wdata, acc, br;
    logic [13:0] rom_addr;
    logic [9:0] rom_rdata;
    logic cy, sk, bk, lr, flt;
    logic [5:0] pg;
    logic [2:0] up;
    logic [3:0] mm [512];
    logic [31:0] q_e[$], q_m[$], q_r[$];
    int n_fail, samples_checked, claims, cyc;
    nibble_alu_skip_logic nibble_alu_skip_logic_i (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest, .ram_addr, .ram_rdata,
        .ram_wdata, .ram_we, .rom_addr, .rom_rdata, .stack_level_free, .stack_claim);
    alu_far_model alu_far_model_i (.ref_clk, .ram_addr, .ram_rdata, .ram_wdata, .ram_we, .rom_addr,
        .rom_rdata, .free_en, .stack_level_free, .stack_claim);
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        // Expected results never seen count as failures
        if (q_e.size() != 0 || q_r.size() != 0) n_fail++;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One access; a spare edge keeps two requests from sharing a time step
    // Only the bench timeout ends a wait
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        q_e.push_back(e);
        q_m.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    // Load-run bit left out: only its effect on the accumulator is judged
    task automatic st();
        rd(5'h04, {19'h0, flt, 1'b0, bk, sk, cy, br, acc}, 32'h17ff);
    endtask
    task automatic op(input op_t c, input logic [3:0] n);
        logic [3:0] m;
        m = mm[pt];
        if (sk || (c == OP_LOAD_IMM && lr)) sk = 1'b0;
        else case (c)
            OP_LOAD_IMM: acc = n;
            OP_TABLE: if (free_en) begin
                {br, acc} = {pg[0], up, acc} ^ {bk, pg, up[2]};
                claims += 2;
            end else flt = 1'b1;
            OP_SEL_UPPER: bk = 1'b1;
            OP_SEL_LOWER: bk = 1'b0;
            OP_ADD_MEM: acc = acc + m;
            OP_ADD_MEM_C: {cy, acc} = acc + m + cy;
            // Adding 16 leaves the inverted carry in the top bit
            OP_ADD_IMM: {sk, acc} = acc + n + 5'h10;
            OP_AND: acc = acc & m;
            OP_OR: acc = acc | m;
            OP_SET_C: cy = 1'b1;
            OP_CLR_C: cy = 1'b0;
            OP_SKIP_CC: sk = !cy;
            OP_COMPL: acc = ~acc;
            OP_ROTATE: {acc, cy} = {cy, acc};
            OP_SET_BIT, OP_CLR_BIT: begin
                mm[pt][n[1:0]] = (c == OP_SET_BIT);
                q_r.push_back({19'h0, pt, mm[pt]});
            end
            OP_SKIP_BIT0: sk = !m[n[1:0]];
            OP_SKIP_EQ_M: sk = (acc == m);
            OP_SKIP_EQ_I: sk = (acc == n);
            default: ;
        endcase
        lr = (c == OP_LOAD_IMM);
        bus(1'b1, 5'h00, {23'h0, n, c});
        st();
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        {acc, br, cy, sk, bk, lr, flt, pt, pg, up} = '0;
        @(posedge ref_clk);
    endtask
    task automatic set_ptr();
        r = rnd();
        pt = r[8:0];
        pg = r[14:9];
        up = r[17:15];
        bus(1'b1, 5'h08, {23'h0, pt});
        bus(1'b1, 5'h10, {26'h0, pg});
        bus(1'b1, 5'h0c, {29'h0, up});
    endtask
    // ****
    // Checker and stimulus
    // ****
    always @(posedge ref_clk) begin
        cyc++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("readdata", q_e.pop_front(), avs_readdata & q_m.pop_front());
        if (ram_we === 1'b1) chk("ram", q_r.size() > 0 ? q_r.pop_front() : 32'hffffffff, {19'h0, ram_addr, ram_wdata});
        if (cyc > 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata, arst_n} = '0;
        {n_fail, samples_checked, claims, cyc} = '0;
        free_en = 1'b1;
        seed = 32'h5868;
        for (int i = 0; i < 512; i++) mm[i] = 4'(i ^ (i >> 4));
        do_reset();
        set_ptr();
        op(OP_TABLE, 4'h0);
        rd(5'h08, {23'h0, pt}, 32'hffffffff);
        rd(5'h18, 32'h0, 32'hffffffff);
        rd(5'h14, 32'h0, 32'hffffffff);
        op(OP_SEL_UPPER, 4'h0);
        op(OP_TABLE, 4'h0);
        op(OP_SEL_LOWER, 4'h0);
        op(OP_TABLE, 4'h0);
        op(OP_SEL_UPPER, 4'h0);
        bus(1'b1, 5'h14, 32'h1);
        bk = 1'b0;
        op(OP_TABLE, 4'h0);
        op(OP_SEL_UPPER, 4'h0);
        do_reset();
        op(OP_TABLE, 4'h0);
        $display("test bank done");
        for (int i = 1; i < 20; i++) begin
            set_ptr();
            op(OP_NOP, 4'h0);
            op(op_t'(i), r[21:18]);
        end
        $display("test sweep done");
        op(OP_NOP, 4'h0);
        op(OP_LOAD_IMM, 4'h5);
        op(OP_LOAD_IMM, 4'h9);
        op(OP_LOAD_IMM, 4'h3);
        $display("test load_run done");
        free_en <= 1'b0;
        // Let the level settle before the model reads it
        @(posedge ref_clk);
        op(OP_TABLE, 4'h0);
        free_en <= 1'b1;
        bus(1'b1, 5'h14, 32'h2);
        flt = 1'b0;
        op(OP_TABLE, 4'h0);
        chk("claim", claims, alu_far_model_i.claim_cyc);
        $display("test stack done");
        for (int i = 0; i < 300; i++) begin
            if (i % 8 == 0) set_ptr();
            r = rnd();
            op(op_t'(r[4:0]), r[8:5]);
        end
        $display("test random done");
        repeat (4) @(posedge ref_clk);
        give_verdict();
    end
endmodule // nibble_alu_skip_logic_tb
